// ===== include/pfsa_pkg.sv
/*
 Shared constants and types for the program flash self access block.
 Assumes a 20 MHz core clock; one instruction cycle is four clocks.
*/
package pfsa_pkg;

	localparam int ADDR_W = 13;
	localparam int DATA_W = 14;
	localparam int CNT_W  = 16;

	// register byte offsets
	localparam logic [7:0] OFF_LOC_LO  = 8'h00;
	localparam logic [7:0] OFF_LOC_HI  = 8'h04;
	localparam logic [7:0] OFF_WORD_LO = 8'h08;
	localparam logic [7:0] OFF_WORD_HI = 8'h0c;
	localparam logic [7:0] OFF_CTRL    = 8'h10;
	localparam logic [7:0] OFF_KEY     = 8'h14;
	localparam logic [7:0] OFF_STATUS  = 8'h18;

	// control and status field positions
	localparam int CTL_SEL = 7;
	localparam int CTL_ERR = 3;
	localparam int CTL_ARM = 2;
	localparam int CTL_GO  = 1;
	localparam int CTL_RD  = 0;
	localparam int ST_DONE = 0;

	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// key tracker values
	localparam logic [1:0] KEY_NONE = 2'h0;
	localparam logic [1:0] KEY_HALF = 2'h1;
	localparam logic [1:0] KEY_FULL = 2'h2;

	// timing
	localparam int CLK_NS   = 50;
	localparam int INSTR_NS = 200;
	localparam int READ_NS  = 2 * INSTR_NS;
	localparam int SETUP_NS = 2 * INSTR_NS;
	localparam int READ_CYC  = (READ_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WRITE_CYC_DEF = 2000;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_READ  = 4'b0010,
		ST_SETUP = 4'b0100,
		ST_PROG  = 4'b1000
	} state_type;

	typedef struct packed {
		logic sel;
		logic err;
		logic arm;
		logic go;
		logic rd;
	} ctl_type;

	// fuse and pin levels; guards are active low as in the fuses
	typedef struct packed {
		logic lock_n;
		logic guard_lo;
		logic guard_hi;
		logic ee_guard;
		logic powerup_delay_timer_en;
		logic powerup_delay_timer_run;
		logic ext_ee_req;
		logic chip_erase;
	} cfg_type;

	// writes blocked but guards open until the pins are through the
	// synchroniser; all zeros would latch the sticky guard at reset
	localparam cfg_type CFG_RST = 8'h70;

endpackage

// ===== hdl/flash_array.sv
/*
 Program flash word array with one port and registered read data.
 Assumes the controller holds address stable for a full read window.
*/
`timescale 1ns/1ns
module flash_array
	import pfsa_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input  wire logic          pclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata_ff
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge pclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata_ff <= mem[addr];
	end

endmodule

// ===== hdl/program_flash_self_access.sv
/*
 Program flash self access controller with APB register port.
 Assumes the core honours core_stall and the fuse pins are static.
*/
// Operation
// - read strobe fetches word over two instruction cycles
// - word registers hold until next read or firmware write
// - instruction execution stalls while flash programs
// - peripherals run, interrupts held pending during stall
// - execution resumes after the two setup cycles and write
// - cleared lock fuse blocks every internal write
// - write needs memory select and arm bit set
// - go accepted only if arm set by earlier write
// - clearing arm does not abort a running write
// - key 55h then AAh then go, uninterrupted, starts write
// - fourteen bit word from high and low word registers
// - completion clears go and sets sticky done flag
// - no automatic verify of written data
// - power-up clears arm; running powerup timer blocks writes
// - internal eeprom access ignores eeprom guard
// - eeprom guard refuses external serial access
// - code guards never gate reads, only writes
// - protection released only by full device erase; write gate follows guard pins, erase clears only the sticky guard
// - go and read only set by software, cleared by hardware
// - warm reset during write sets abort flag, keeps data
// - memory select frozen while an operation runs
`timescale 1ns/1ns
module program_flash_self_access
	import pfsa_pkg::*;
#(
	parameter int WRITE_CYC = WRITE_CYC_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        warm_reset,
	input  wire cfg_type     cfg_pins,
	output logic             core_stall,
	output logic             ext_ee_grant,
	output logic             guard_active
);

	////////////////////////////////////////////////////////////
	// pin synchroniser: value moves once stages two and three agree
	cfg_type cfg_s1_ff, cfg_s2_ff, cfg_s3_ff, cfg_ff, nxt_cfg;

	always_comb begin
		for (int i = 0; i < $bits(cfg_type); i++) begin
			nxt_cfg[i] = (cfg_s2_ff[i] == cfg_s3_ff[i]) ?
				cfg_s3_ff[i] : cfg_ff[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_s1_ff <= CFG_RST;
			cfg_s2_ff <= CFG_RST;
			cfg_s3_ff <= CFG_RST;
			cfg_ff    <= CFG_RST;
		end else begin
			cfg_s1_ff <= cfg_pins;
			cfg_s2_ff <= cfg_s1_ff;
			cfg_s3_ff <= cfg_s2_ff;
			cfg_ff    <= nxt_cfg;
		end
	end

	////////////////////////////////////////////////////////////
	// register and sequencer state
	state_type         state_ff, nxt_state;
	ctl_type           ctl_ff, nxt_ctl;
	logic [1:0]        key_ff, nxt_key;
	logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
	logic [7:0]        loc_lo_ff, nxt_loc_lo;
	logic [4:0]        loc_hi_ff, nxt_loc_hi;
	logic [7:0]        word_lo_ff, nxt_word_lo;
	logic [5:0]        word_hi_ff, nxt_word_hi;
	logic              done_ff, nxt_done;
	logic              guard_ff, nxt_guard;
	logic              grant_ff, nxt_grant;
	logic              stall_ff, nxt_stall;
	logic [31:0]       rdata_ff, nxt_rdata;
	logic              rdy_ff, nxt_rdy;
	logic              err_ff, nxt_err;
	logic [DATA_W-1:0] mem_q;
	logic              mem_we;
	logic              wr_acc, idle, busy_wr, write_ok, go_ok;
	logic              mapped;

	assign wr_acc  = psel & penable & pwrite & rdy_ff;
	assign idle    = (state_ff == ST_IDLE);
	assign busy_wr = (state_ff == ST_SETUP) | (state_ff == ST_PROG);

	// write permission
	// a full protect blocks writes; area split is not modelled
	assign write_ok = cfg_ff.lock_n &
		(cfg_ff.guard_lo | cfg_ff.guard_hi) &
		~(cfg_ff.powerup_delay_timer_en & cfg_ff.powerup_delay_timer_run);

	assign go_ok = pwdata[CTL_GO] & ctl_ff.arm & ctl_ff.sel &
		(key_ff == KEY_FULL) & write_ok & idle;

	assign mem_we = (state_ff == ST_PROG) && (cnt_ff == '0);

	flash_array #(
		.AW (ADDR_W),
		.DW (DATA_W)
	) u_array (
		.pclk     (pclk),
		.we       (mem_we),
		.addr     ({loc_hi_ff, loc_lo_ff}),
		.wdata    ({word_hi_ff, word_lo_ff}),
		.rdata_ff (mem_q)
	);

	always_comb begin
		nxt_state   = state_ff;
		nxt_ctl     = ctl_ff;
		nxt_key     = key_ff;
		nxt_cnt     = cnt_ff;
		nxt_loc_lo  = loc_lo_ff;
		nxt_loc_hi  = loc_hi_ff;
		nxt_word_lo = word_lo_ff;
		nxt_word_hi = word_hi_ff;
		nxt_done    = done_ff;
		if (wr_acc) begin
			// any other write breaks the key sequence
			nxt_key = KEY_NONE;
			case (paddr)
				OFF_LOC_LO:  nxt_loc_lo = pwdata[7:0];
				OFF_LOC_HI:  nxt_loc_hi = pwdata[4:0];
				OFF_WORD_LO: nxt_word_lo = pwdata[7:0];
				OFF_WORD_HI: nxt_word_hi = pwdata[5:0];
				OFF_KEY: begin
					if (pwdata[7:0] == KEY_FIRST) begin
						nxt_key = KEY_HALF;
					end else if (pwdata[7:0] == KEY_SECOND &&
						key_ff == KEY_HALF) begin
						nxt_key = KEY_FULL;
					end
				end
				OFF_STATUS: begin
					if (pwdata[ST_DONE]) begin
						nxt_done = 1'b0;
					end
				end
				OFF_CTRL: begin
					if (idle) begin
						nxt_ctl.sel = pwdata[CTL_SEL];
					end
					// arm change never touches the sequencer
					nxt_ctl.arm = pwdata[CTL_ARM];
					nxt_ctl.err = ctl_ff.err & pwdata[CTL_ERR];
					if (go_ok) begin
						nxt_ctl.go = 1'b1;
						nxt_state  = ST_SETUP;
						nxt_cnt    = CNT_W'(SETUP_CYC - 1);
					end else if (pwdata[CTL_RD] & idle &
						ctl_ff.sel) begin
						nxt_ctl.rd = 1'b1;
						nxt_state  = ST_READ;
						nxt_cnt    = CNT_W'(READ_CYC - 1);
					end
				end
				default: ;
			endcase
		end
		case (state_ff)
			ST_IDLE: ;
			ST_READ: begin
				if (cnt_ff == '0) begin
					nxt_word_lo = mem_q[7:0];
					nxt_word_hi = mem_q[DATA_W-1:8];
					nxt_ctl.rd  = 1'b0;
					nxt_state   = ST_IDLE;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			ST_SETUP: begin
				if (cnt_ff == '0) begin
					nxt_state = ST_PROG;
					nxt_cnt   = CNT_W'(WRITE_CYC - 1);
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			ST_PROG: begin
				if (cnt_ff == '0) begin
					nxt_ctl.go = 1'b0;
					nxt_done   = 1'b1;
					nxt_state  = ST_IDLE;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		// warm reset keeps data, location and select
		if (warm_reset) begin
			nxt_ctl.err = ctl_ff.err | busy_wr;
			nxt_ctl.arm = 1'b0;
			nxt_ctl.go  = 1'b0;
			nxt_ctl.rd  = 1'b0;
			nxt_key     = KEY_NONE;
			nxt_cnt     = '0;
			nxt_state   = ST_IDLE;
		end
	end

	// stall only while programming; the interrupt
	// controller sees core_stall and keeps requests pending
	assign nxt_stall = (nxt_state == ST_PROG);

	// sticky protection, cleared by full erase or by presetn
	assign nxt_guard = cfg_ff.chip_erase ? 1'b0 :
		(guard_ff | ~cfg_ff.guard_lo | ~cfg_ff.guard_hi |
		 ~cfg_ff.ee_guard);

	// guard gates the serial port, not the core
	assign nxt_grant = cfg_ff.ext_ee_req & cfg_ff.ee_guard &
		~guard_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff   <= ST_IDLE;
			ctl_ff     <= '0;
			key_ff     <= KEY_NONE;
			cnt_ff     <= '0;
			loc_lo_ff  <= '0;
			loc_hi_ff  <= '0;
			word_lo_ff <= '0;
			word_hi_ff <= '0;
			done_ff    <= 1'b0;
			guard_ff   <= 1'b0;
			grant_ff   <= 1'b0;
			stall_ff   <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			ctl_ff     <= nxt_ctl;
			key_ff     <= nxt_key;
			cnt_ff     <= nxt_cnt;
			loc_lo_ff  <= nxt_loc_lo;
			loc_hi_ff  <= nxt_loc_hi;
			word_lo_ff <= nxt_word_lo;
			word_hi_ff <= nxt_word_hi;
			done_ff    <= nxt_done;
			guard_ff   <= nxt_guard;
			grant_ff   <= nxt_grant;
			stall_ff   <= nxt_stall;
		end
	end

	////////////////////////////////////////////////////////////
	// APB answer: data registered in setup, ready in access
	always_comb begin
		mapped    = 1'b1;
		nxt_rdata = '0;
		case (paddr)
			OFF_LOC_LO:  nxt_rdata[7:0] = loc_lo_ff;
			OFF_LOC_HI:  nxt_rdata[4:0] = loc_hi_ff;
			OFF_WORD_LO: nxt_rdata[7:0] = word_lo_ff;
			OFF_WORD_HI: nxt_rdata[5:0] = word_hi_ff;
			OFF_CTRL: begin
				nxt_rdata[CTL_SEL] = ctl_ff.sel;
				nxt_rdata[CTL_ERR] = ctl_ff.err;
				nxt_rdata[CTL_ARM] = ctl_ff.arm;
				nxt_rdata[CTL_GO]  = ctl_ff.go;
				nxt_rdata[CTL_RD]  = ctl_ff.rd;
			end
			OFF_KEY:    ;
			OFF_STATUS: nxt_rdata[ST_DONE] = done_ff;
			default:    mapped = 1'b0;
		endcase
		nxt_rdy = psel & ~penable;
		nxt_err = psel & ~penable & ~mapped;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= '0;
			rdy_ff   <= 1'b0;
			err_ff   <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			rdy_ff   <= nxt_rdy;
			err_ff   <= nxt_err;
		end
	end

	assign prdata       = rdata_ff;
	assign pready       = rdy_ff;
	assign pslverr      = err_ff;
	assign core_stall   = stall_ff;
	assign ext_ee_grant = grant_ff;
	assign guard_active = guard_ff;

	////////////////////////////////////////////////////////////
	// checks
	sequence s_go_rise;
		$rose(ctl_ff.go);
	endsequence

	sequence s_setup_gap;
		!stall_ff [*8] ##1 stall_ff;
	endsequence

	a_go_needs_key: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_go_rise |-> $past(key_ff) == KEY_FULL)
		else $error("go set without unlock key");

	a_setup_then_stall: assert property (
		@(posedge pclk) disable iff (!presetn || warm_reset)
		s_go_rise |-> s_setup_gap)
		else $error("stall not after two setup slots");

	a_read_window: assert property (
		@(posedge pclk) disable iff (!presetn || warm_reset)
		$rose(ctl_ff.rd) |-> ctl_ff.rd [*8] ##1 !ctl_ff.rd)
		else $error("read window not two instruction cycles");

	a_arm_same_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == OFF_CTRL && !ctl_ff.arm
		|=> !$rose(ctl_ff.go))
		else $error("go accepted with arm set in same write");

	a_lock_blocks: assert property (
		@(posedge pclk) disable iff (!presetn)
		!cfg_ff.lock_n && idle |=> !ctl_ff.go)
		else $error("write started while locked");

	a_done_on_end: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(ctl_ff.go) && !$past(warm_reset) |-> done_ff)
		else $error("done flag not set at completion");

	a_sel_frozen: assert property (
		@(posedge pclk) disable iff (!presetn)
		!idle |=> ctl_ff.sel == $past(ctl_ff.sel))
		else $error("memory select changed while busy");

	a_abort_flag: assert property (
		@(posedge pclk) disable iff (!presetn)
		warm_reset && busy_wr |=> ctl_ff.err && !ctl_ff.go)
		else $error("abort flag not set on warm reset");

	a_word_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		idle && !wr_acc |=> $stable(word_lo_ff))
		else $error("word changed without read or write");

endmodule

// ===== verification/core_model.sv
/*
 core and peripheral side model: counts instructions and timer ticks.
 assumes core_stall comes from the controller on the same clock.
*/
`timescale 1ns/1ns
module core_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        core_stall,
	output logic      [15:0] instr_cnt_ff,
	output logic      [15:0] tick_cnt_ff,
	output logic             irq_pend_ff
);
	logic [1:0] phase_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_ff <= 2'h0;
			instr_cnt_ff <= 16'h0;
			tick_cnt_ff <= 16'h0;
			irq_pend_ff <= 1'b0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 16'h1;
			irq_pend_ff <= irq_pend_ff | core_stall;
			if (!core_stall) begin
				phase_ff <= phase_ff + 2'h1;
				if (phase_ff == 2'h3)
					instr_cnt_ff <= instr_cnt_ff + 16'h1;
			end
		end
	end
endmodule

// ===== verification/program_flash_self_access_tb_top.sv
/*
 self-checking bench: APB master, random words, corner cases.
 assumes WRITE_CYC of 20 and cfg pins settling in a few cycles.
*/
`timescale 1ns/1ns
module program_flash_self_access_tb_top;
	import pfsa_pkg::*;
	localparam int WC = 20;
	logic        pclk, presetn, psel, penable, pwrite, warm_reset;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, er, core_stall, ext_ee_grant, guard_active;
	cfg_type     cfg;
	logic [15:0] ic, tc;
	logic        ip;
	logic [12:0] l;
	logic [13:0] v, w;
	integer      seed = 51398;
	int          mismatches = 0, comparisons = 0, sc, n;
	program_flash_self_access #(.WRITE_CYC(WC)) dut (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .warm_reset(warm_reset), .cfg_pins(cfg),
		.core_stall(core_stall), .ext_ee_grant(ext_ee_grant),
		.guard_active(guard_active));
	core_model core (.pclk(pclk), .presetn(presetn), .core_stall(core_stall),
		.instr_cnt_ff(ic), .tick_cnt_ff(tc), .irq_pend_ff(ip));
	////////////////////////////////////////////////////////////////////////
	task results;
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			mismatches++;
			$display("MISMATCH %0t no pready", $time);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task go(input logic [7:0] pre, input bit key);
		apb(1, OFF_LOC_LO, {24'h0, l[7:0]});
		apb(1, OFF_LOC_HI, {27'h0, l[12:8]});
		apb(1, OFF_WORD_LO, {24'h0, v[7:0]});
		apb(1, OFF_WORD_HI, {26'h0, v[13:8]});
		apb(1, OFF_CTRL, 32'h80);
		apb(1, OFF_CTRL, {24'h0, pre});
		if (key) begin
			apb(1, OFF_KEY, {24'h0, KEY_FIRST});
			apb(1, OFF_KEY, {24'h0, KEY_SECOND});
		end
		apb(1, OFF_CTRL, 32'h86);
		n = 0;
		while (core_stall !== 1'b1 && n < 30) begin
			@(posedge pclk);
			n++;
		end
	endtask
	// counts the rest of the stall; instructions must not advance
	task wend;
		logic [15:0] i0, t0;
		i0 = ic;
		t0 = tc;
		sc = 0;
		while (core_stall === 1'b1 && sc < 200) begin
			@(posedge pclk);
			sc++;
		end
		chk(ic, i0, "instr ran in stall");
		chk(16'(tc - t0), sc, "timer stopped in stall");
	endtask
	task rdw;
		apb(1, OFF_LOC_LO, {24'h0, l[7:0]});
		apb(1, OFF_LOC_HI, {27'h0, l[12:8]});
		apb(1, OFF_CTRL, 32'h80);
		apb(1, OFF_WORD_LO, 32'hc3);
		apb(1, OFF_WORD_HI, 32'h0c);
		apb(1, OFF_CTRL, 32'h81);
		n = 0;
		do begin
			apb(0, OFF_CTRL, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
		chk(rd[CTL_RD], 1'b0, "read not cleared");
		apb(0, OFF_WORD_LO, 32'h0);
		w[7:0] = rd[7:0];
		apb(0, OFF_WORD_HI, 32'h0);
		w[13:8] = rd[5:0];
	endtask
	task blocked(input logic [7:0] pre, input bit key);
		v = ~w;
		go(pre, key);
		chk(core_stall, 1'b0, "write not refused");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#3000000;
		mismatches++;
		results;
	end
	initial begin
		{presetn, psel, penable, pwrite, warm_reset} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		cfg = 8'hf0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(0, OFF_CTRL, 32'h0);
		chk(rd, 32'h0, "ctrl reset");
		apb(0, 8'h1c, 32'h0);
		chk(er, 1'b1, "unmapped err");
		chk(rd, 32'h0, "unmapped");
		for (int t = 0; t < 4; t++) begin
			l = $random(seed);
			v = $random(seed);
			if (t == 0)
				v = 14'h3fff;
			go(8'h84, 1);
			wend;
			chk(sc, WC, "stall length");
			chk(ip, 1'b1, "irq not queued");
			apb(0, OFF_STATUS, 32'h0);
			chk(rd[ST_DONE], 1'b1, "done");
			apb(0, OFF_CTRL, 32'h0);
			chk(rd[CTL_GO], 1'b0, "go left set");
			apb(1, OFF_STATUS, 32'h1);
			apb(0, OFF_STATUS, 32'h0);
			chk(rd[ST_DONE], 1'b0, "done clear");
			rdw;
			chk(w, v, "readback");
			apb(0, OFF_WORD_LO, 32'h0);
			chk(rd[7:0], v[7:0], "word held");
		end
		blocked(8'h80, 1);
		blocked(8'h84, 0);
		cfg.lock_n <= 1'b0;
		blocked(8'h84, 1);
		cfg.lock_n <= 1'b1;
		cfg.powerup_delay_timer_en <= 1'b1;
		cfg.powerup_delay_timer_run <= 1'b1;
		blocked(8'h84, 1);
		cfg.powerup_delay_timer_run <= 1'b0;
		rdw;
		chk(w, 14'(~v), "memory altered");
		v = $random(seed);
		go(8'h84, 1);
		apb(1, OFF_CTRL, 32'h0);
		apb(0, OFF_CTRL, 32'h0);
		chk({rd[CTL_SEL], rd[CTL_GO]}, 2'b11, "busy ctrl");
		wend;
		apb(0, OFF_STATUS, 32'h0);
		chk(rd[ST_DONE], 1'b1, "arm clear aborted");
		rdw;
		chk(w, v, "readback");
		v = $random(seed);
		go(8'h84, 1);
		warm_reset <= 1'b1;
		@(posedge pclk);
		warm_reset <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(core_stall, 1'b0, "stall after abort");
		apb(0, OFF_CTRL, 32'h0);
		chk(rd[7:0], 8'h88, "abort flag");
		apb(0, OFF_WORD_LO, 32'h0);
		chk(rd[7:0], v[7:0], "word kept");
		cfg.ext_ee_req <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(ext_ee_grant, 1'b1, "grant");
		cfg.ee_guard <= 1'b0;
		repeat (6) @(posedge pclk);
		chk({ext_ee_grant, guard_active}, 2'b01, "ee guard");
		cfg.ee_guard <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(guard_active, 1'b1, "guard sticky");
		cfg.chip_erase <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(guard_active, 1'b0, "erase release");
		results;
	end
endmodule
